// ### verilog/dbm_pin_mux.sv
// Pin function mux for data-bus bits 5 to 13
`timescale 1ns/100ps

// Functional notes
// - Software parallel: pins take write data, drive read data.
// - Hardware parallel or byte: used pins are read-only outputs, writes ignored.
// - Software byte: bits 5 to 7 carry write and read data.
// - Hardware byte: bits 5 to 7 only drive read data.
// - Serial: bit 5 is CRC-enable strap, caught at full-reset release.
// - CRC strap high appends one CRC word after last result; low sends none.
// - Interface strap high: bit 9 caught at reset, high byte, low serial.
// - After capture, bit 9 changes are ignored until next full reset.
// - Software serial: bit 10 is the serial programming input.
// - Serial: bit 11 drives secondary serial output line.
// - Serial: bit 12 drives primary serial output line.
// - Hardware serial: bit 13 is oversampling bit 0, caught at reset release.
// - Interface strap latched at full reset: low parallel, high serial or byte.
// - Range straps latched at full reset: 00 software, else hardware.
// - Single-line strap: low uses primary only, high both lines.
module dbm_pin_mux (
  // Clock and synchronous reset
  input wire logic clk,
  input wire logic rst_n,
  // Strap pins from outside
  input wire logic interface_kind_strap,
  input wire logic [1:0] control_range_straps,
  input wire logic single_line_output_strap,
  // Pads of bits 5 to 13
  input wire logic [8:0] pin_in,
  output logic [8:0] pin_out,
  output logic [8:0] pin_oe_n,
  // Parallel access strobes from the access decoder
  input wire logic rd_active,
  input wire logic wr_active,
  input wire logic [8:0] rd_data,
  // Serial engine side
  input wire dbm_pkg::dbm_serout_t ser_out,
  input wire logic ser_oe,
  input wire logic last_result_done,
  // Results toward the core
  output logic [8:0] wr_data_ff,
  output logic wr_strobe_ff,
  output logic serial_program_in_ff,
  output logic crc_word_req_ff,
  output logic secondary_line_en_ff,
  output logic oversample_sel_bit0_ff,
  output logic crc_append_strap_ff,
  output logic [5:0] mode_ff
);

  // ****************************************
  // Input synchronisers
  // ****************************************
  logic [8:0] pin_s1_ff;
  logic [8:0] pin_s2_ff;
  logic [3:0] strap_s1_ff;
  logic [3:0] strap_s2_ff;
  logic rst_seen_ff;
  logic strap_done_ff;
  dbm_pkg::dbm_straps_t straps_ff;
  dbm_pkg::dbm_mode_t mode_cur_ff;
  dbm_pkg::dbm_mode_t nxt_mode;
  logic [8:0] nxt_oe_n;
  logic [8:0] nxt_out;
  logic [8:0] in_mask;
  logic ser_mode;

  // Two flip-flops on every pad of the slice
  always_ff @(posedge clk) begin
    pin_s1_ff <= pin_in;
    pin_s2_ff <= pin_s1_ff;
  end

  // Two flip-flops on the dedicated strap pins
  always_ff @(posedge clk) begin
    strap_s1_ff <= {interface_kind_strap, control_range_straps, single_line_output_strap};
    strap_s2_ff <= strap_s1_ff;
  end

  // ****************************************
  // Strap capture at reset release
  // ****************************************
  // Marks the first cycle after reset is released
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      rst_seen_ff <= 1'b0;
    end else begin
      rst_seen_ff <= 1'b1;
    end
  end

  // Straps are settled one cycle after capture, pads may then drive
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      strap_done_ff <= 1'b0;
    end else begin
      strap_done_ff <= rst_seen_ff;
    end
  end

  // Latch straps once, then hold until next full reset
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      straps_ff <= '0;
    end else if (!rst_seen_ff) begin
      straps_ff.iface_kind <= strap_s2_ff[3];
      straps_ff.range_sel <= strap_s2_ff[2:1];
      straps_ff.single_line <= strap_s2_ff[0];
      straps_ff.byte_sel <= strap_s2_ff[3] & pin_s2_ff[dbm_pkg::IDX_BYTESW];
      straps_ff.crc_append <= pin_s2_ff[dbm_pkg::IDX_CRC];
      straps_ff.os_bit0 <= pin_s2_ff[dbm_pkg::IDX_OS0];
    end
  end

  // ****************************************
  // Mode decode
  // ****************************************
  // Interface and control kind give one of six modes
  always_comb begin
    if (!straps_ff.iface_kind) begin
      nxt_mode = (straps_ff.range_sel == dbm_pkg::RNG_SOFTWARE) ?
                 dbm_pkg::MODE_SW_PAR : dbm_pkg::MODE_HW_PAR;
    end else if (straps_ff.byte_sel) begin
      nxt_mode = (straps_ff.range_sel == dbm_pkg::RNG_SOFTWARE) ?
                 dbm_pkg::MODE_SW_BYTE : dbm_pkg::MODE_HW_BYTE;
    end else begin
      nxt_mode = (straps_ff.range_sel == dbm_pkg::RNG_SOFTWARE) ?
                 dbm_pkg::MODE_SW_SER : dbm_pkg::MODE_HW_SER;
    end
  end

  // Mode register, follows the latched straps
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      mode_cur_ff <= dbm_pkg::MODE_SW_PAR;
    end else begin
      mode_cur_ff <= nxt_mode;
    end
  end

  // Either serial mode, shared by the CRC and second-line outputs
  always_comb begin
    ser_mode = (mode_cur_ff == dbm_pkg::MODE_SW_SER) || (mode_cur_ff == dbm_pkg::MODE_HW_SER);
  end

  // ****************************************
  // Pin direction and output data
  // ****************************************
  always_comb begin
    nxt_oe_n = dbm_pkg::OE_N_RST;
    nxt_out = dbm_pkg::DOUT_RST;
    in_mask = dbm_pkg::NONE_MASK;
    unique case (mode_cur_ff)
      dbm_pkg::MODE_SW_PAR: begin
        in_mask = dbm_pkg::ALL_MASK;
        if (rd_active) begin
          nxt_oe_n = ~dbm_pkg::ALL_MASK;
          nxt_out = rd_data;
        end
      end
      dbm_pkg::MODE_HW_PAR: begin
        if (rd_active) begin
          nxt_oe_n = ~dbm_pkg::ALL_MASK;
          nxt_out = rd_data;
        end
      end
      dbm_pkg::MODE_SW_BYTE: begin
        in_mask = dbm_pkg::BYTE_DATA_MASK;
        if (rd_active) begin
          nxt_oe_n = ~dbm_pkg::BYTE_DATA_MASK;
          nxt_out = rd_data & dbm_pkg::BYTE_DATA_MASK;
        end
      end
      dbm_pkg::MODE_HW_BYTE: begin
        if (rd_active) begin
          nxt_oe_n = ~dbm_pkg::BYTE_DATA_MASK;
          nxt_out = rd_data & dbm_pkg::BYTE_DATA_MASK;
        end
      end
      dbm_pkg::MODE_SW_SER, dbm_pkg::MODE_HW_SER: begin
        if (ser_oe) begin
          nxt_oe_n[dbm_pkg::IDX_SERIAL_OUT_PRIMARY] = 1'b0;
          nxt_out[dbm_pkg::IDX_SERIAL_OUT_PRIMARY] = ser_out.primary;
          if (straps_ff.single_line) begin
            nxt_oe_n[dbm_pkg::IDX_SERIAL_OUT_SECONDARY] = 1'b0;
            nxt_out[dbm_pkg::IDX_SERIAL_OUT_SECONDARY] = ser_out.secondary;
          end
        end
      end
      default: begin
        nxt_oe_n = dbm_pkg::OE_N_RST;
      end
    endcase
  end

  // ****************************************
  // Registered pad drivers
  // ****************************************
  // Pad enables, all off in reset and until the straps are settled
  always_ff @(posedge clk) begin
    if (!rst_n || !strap_done_ff) begin
      pin_oe_n <= dbm_pkg::OE_N_RST;
    end else begin
      pin_oe_n <= nxt_oe_n;
    end
  end

  // Pad data, cleared together with the enables
  always_ff @(posedge clk) begin
    if (!rst_n || !strap_done_ff) begin
      pin_out <= dbm_pkg::DOUT_RST;
    end else begin
      pin_out <= nxt_out;
    end
  end

  // ****************************************
  // Write capture and serial input
  // ****************************************
  // Write strobe only in software parallel and byte modes
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      wr_strobe_ff <= 1'b0;
    end else begin
      wr_strobe_ff <= wr_active && (in_mask != dbm_pkg::NONE_MASK) && strap_done_ff;
    end
  end

  // Write data masked to the pins that take writes in this mode
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      wr_data_ff <= dbm_pkg::DOUT_RST;
    end else if (wr_active) begin
      wr_data_ff <= pin_s2_ff & in_mask;
    end
  end

  // ****************************************
  // Serial programming input
  // ****************************************
  // Serial programming line only in software serial mode
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      serial_program_in_ff <= 1'b0;
    end else begin
      serial_program_in_ff <= (mode_cur_ff == dbm_pkg::MODE_SW_SER) &&
                              pin_s2_ff[dbm_pkg::IDX_SDI];
    end
  end

  // ****************************************
  // Strap-driven outputs
  // ****************************************
  // CRC enable strap shown only in serial modes
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      crc_append_strap_ff <= dbm_pkg::STRAP_RST;
    end else begin
      crc_append_strap_ff <= straps_ff.crc_append && ser_mode;
    end
  end

  // Second serial line enable shown only in serial modes
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      secondary_line_en_ff <= dbm_pkg::STRAP_RST;
    end else begin
      secondary_line_en_ff <= straps_ff.single_line && ser_mode;
    end
  end

  // Oversampling bit 0 shown only in hardware serial mode
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      oversample_sel_bit0_ff <= dbm_pkg::STRAP_RST;
    end else begin
      oversample_sel_bit0_ff <= straps_ff.os_bit0 &&
                                (mode_cur_ff == dbm_pkg::MODE_HW_SER);
    end
  end

  // ****************************************
  // CRC request and mode outputs
  // ****************************************
  // CRC word follows the last result only with the strap set
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      crc_word_req_ff <= 1'b0;
    end else begin
      crc_word_req_ff <= last_result_done && straps_ff.crc_append && ser_mode;
    end
  end

  // Registered copy of the decoded mode for the core
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      mode_ff <= dbm_pkg::MODE_SW_PAR;
    end else begin
      mode_ff <= mode_cur_ff;
    end
  end

endmodule : dbm_pin_mux

// ### verilog/dbm_pkg.sv
// Package of constants and carrier types for the data-bus pin function mux
package dbm_pkg;

  // ****************************************
  // Pin slice and positions
  // ****************************************
  localparam int unsigned LO_PIN = 5;
  localparam int unsigned HI_PIN = 13;
  localparam int unsigned NPINS = 9;
  localparam int unsigned IDX_CRC = 0;
  localparam int unsigned IDX_BYTESW = 4;
  localparam int unsigned IDX_SDI = 5;
  localparam int unsigned IDX_SERIAL_OUT_SECONDARY = 6;
  localparam int unsigned IDX_SERIAL_OUT_PRIMARY = 7;
  localparam int unsigned IDX_OS0 = 8;

  // ****************************************
  // Reset values and encodings
  // ****************************************
  localparam logic [1:0] RNG_SOFTWARE = 2'h0;
  localparam logic [8:0] OE_N_RST = 9'h1ff;
  localparam logic [8:0] DOUT_RST = 9'h000;
  localparam logic [8:0] BYTE_DATA_MASK = 9'h007;
  localparam logic [8:0] ALL_MASK = 9'h1ff;
  localparam logic [8:0] NONE_MASK = 9'h000;
  localparam logic STRAP_RST = 1'h0;

  // ****************************************
  // Mode encoding, one-hot
  // ****************************************
  typedef enum logic [5:0] {
    MODE_SW_PAR = 6'h01,
    MODE_HW_PAR = 6'h02,
    MODE_SW_BYTE = 6'h04,
    MODE_HW_BYTE = 6'h08,
    MODE_SW_SER = 6'h10,
    MODE_HW_SER = 6'h20
  } dbm_mode_t;

  // ****************************************
  // Latched strap set
  // ****************************************
  typedef struct packed {
    logic iface_kind;
    logic [1:0] range_sel;
    logic byte_sel;
    logic crc_append;
    logic single_line;
    logic os_bit0;
  } dbm_straps_t;

  // ****************************************
  // Serial output pair and CRC phase bit from the core
  // ****************************************
  typedef struct packed {
    logic primary;
    logic secondary;
    logic crc_phase;
  } dbm_serout_t;

endpackage : dbm_pkg

// ### sim/dbm_host.sv
// Host-side model of the pads of bits 5 to 13
`timescale 1ns/100ps
module dbm_host (
  // Device pad drive
  input wire logic [8:0] pin_out,
  input wire logic [8:0] pin_oe_n,
  // Host levels, unused pins held low by the bench except bit 9, held high in serial modes
  input wire logic [8:0] host_val,
  // Resolved wire levels
  output logic [8:0] pin_in
);
  // Device wins where it drives, otherwise the host level
  assign pin_in = (~pin_oe_n & pin_out) | (pin_oe_n & host_val);
endmodule : dbm_host

// ### sim/dbm_pin_mux_asserts.sv
// Port checker for the data-bus pin mux
`timescale 1ns/100ps
module dbm_pin_mux_asserts (
  // Clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // Requests
  input wire logic rd_active,
  input wire logic wr_active,
  input wire logic [8:0] rd_data,
  input wire dbm_pkg::dbm_serout_t ser_out,
  input wire logic ser_oe,
  input wire logic last_result_done,
  // Results
  input wire logic [8:0] pin_out,
  input wire logic [8:0] pin_oe_n,
  input wire logic wr_strobe_ff,
  input wire logic crc_word_req_ff,
  input wire logic secondary_line_en_ff,
  input wire logic crc_append_strap_ff,
  input wire logic [5:0] mode_ff
);
  default clocking @(posedge clk);
  endclocking
  default disable iff (!rst_n);
  // Serial mode flag
  logic ser_m;
  assign ser_m = mode_ff[4] | mode_ff[5];
  a_idle_hiz: assert property ((!rd_active && !ser_oe)[*2] |-> pin_oe_n == 9'h1ff)
    else $error("pads driven while idle");
  a_par_read: assert property (mode_ff[0] && rd_active |=>
    pin_oe_n == 9'h000 && pin_out == $past(rd_data)) else $error("parallel read wrong");
  a_byte_read: assert property (mode_ff[3] && rd_active |=>
    pin_oe_n == 9'h1f8 && pin_out[2:0] == $past(rd_data[2:0])) else $error("byte read wrong");
  a_sw_write: assert property ((mode_ff[0] || mode_ff[2]) && wr_active |=> wr_strobe_ff)
    else $error("write not taken");
  a_write_refused: assert property (!(mode_ff[0] || mode_ff[2]) |=> !wr_strobe_ff)
    else $error("write taken in read-only mode");
  a_ser_lines: assert property (ser_m && ser_oe |=> !pin_oe_n[7] &&
    pin_out[7] == $past(ser_out.primary) && pin_oe_n[6] == !secondary_line_en_ff)
    else $error("serial lines wrong");
  a_ser_only: assert property (ser_m |-> (pin_oe_n | 9'h0c0) == 9'h1ff)
    else $error("non-serial pad driven");
  a_crc_pulse: assert property (1 |=> crc_word_req_ff ==
    ($past(last_result_done) && crc_append_strap_ff)) else $error("crc request wrong");
  a_mode_held: assert property (mode_ff != 6'h01 |=> $stable(mode_ff))
    else $error("mode changed after latch");
endmodule : dbm_pin_mux_asserts

bind dbm_pin_mux dbm_pin_mux_asserts dbm_pin_mux_asserts_inst (.*);

// ### sim/tb.sv
// Self-checking bench for the data-bus pin mux
`timescale 1ns/100ps
module tb;
  logic clk = 1'h0;
  logic rst_n = 1'h0;
  logic interface_kind_strap = 1'h0;
  logic [1:0] control_range_straps = 2'h0;
  logic single_line_output_strap = 1'h0;
  logic [8:0] host_val = 9'h000;
  logic rd_active = 1'h0;
  logic wr_active = 1'h0;
  logic [8:0] rd_data = 9'h000;
  dbm_pkg::dbm_serout_t ser_out = 3'h0;
  logic ser_oe = 1'h0;
  logic last_result_done = 1'h0;
  logic [8:0] pin_in, pin_out, pin_oe_n, wr_data_ff;
  logic wr_strobe_ff, serial_program_in_ff, crc_word_req_ff, secondary_line_en_ff;
  logic oversample_sel_bit0_ff, crc_append_strap_ff;
  logic [5:0] mode_ff;
  int num_errors = 0;
  int cmp_count = 0;
  dbm_pin_mux dbm_pin_mux_inst (.*);
  dbm_host dbm_host_inst (.*);
  // Free-running clock
  always #2 clk = ~clk;
  // Advance n edges, then step off the edge
  task automatic tick(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask : tick
  // Compare one result
  task automatic chk(input string nm, input logic [8:0] e, input logic [8:0] g);
    cmp_count++;
    if (g !== e) begin
      num_errors++;
      $display("ERROR %s expected %h seen %h", nm, e, g);
    end
  endtask : chk
  // Print the verdict and stop
  task automatic give_verdict();
    if (num_errors == 0 && cmp_count > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask : give_verdict
  // Expected one-hot mode from the strap levels
  function automatic logic [5:0] exp_mode(logic k, logic [1:0] r, logic b);
    if (!k) return (r != 2'h0) ? 6'h02 : 6'h01;
    if (b) return (r != 2'h0) ? 6'h08 : 6'h04;
    return (r != 2'h0) ? 6'h20 : 6'h10;
  endfunction : exp_mode
  // Watchdog against a hang
  initial begin
    #20000;
    num_errors++;
    give_verdict();
  end
  // Each parallel mode four times, the rest twice, with random range, CRC, oversampling and single-line straps, then write, read, serial and CRC traffic
  initial begin
    logic b, crc, os, s, wok;
    logic [5:0] md;
    logic [8:0] d, eoe;
    void'($urandom(58431));
    for (int m = 0; m < 16; m++) begin
      b = m[1];
      interface_kind_strap = m[0];
      control_range_straps = m[2] ? 2'($urandom_range(3, 1)) : 2'h0;
      {crc, os, single_line_output_strap} = 3'($urandom);
      host_val = {os, 3'h0, b, 3'h0, crc};
      rst_n = 1'h0;
      tick(4);
      rst_n = 1'h1;
      tick(4);
      md = exp_mode(interface_kind_strap, control_range_straps, b);
      s = md[4] | md[5];
      wok = md[0] | md[2];
      chk("mode", 9'(md), 9'(mode_ff));
      chk("crc_strap", 9'(s & crc), 9'(crc_append_strap_ff));
      chk("os_bit0", 9'(md[5] & os), 9'(oversample_sel_bit0_ff));
      chk("sec_en", 9'(s & single_line_output_strap), 9'(secondary_line_en_ff));
      d = 9'($urandom) & (md[0] | md[1] ? 9'h1ff : md[2] | md[3] ? 9'h007 : md[4] ? 9'h020 : 9'h000);
      d = d | (s ? 9'h010 : 9'h000);
      host_val = d;
      tick(3);
      chk("mode_kept", 9'(md), 9'(mode_ff));
      wr_active = 1'h1;
      tick(1);
      wr_active = 1'h0;
      chk("wr_strobe", 9'(wok), 9'(wr_strobe_ff));
      if (wok) chk("wr_data", d, wr_data_ff);
      chk("sdi", 9'(md[4] & d[5]), 9'(serial_program_in_ff));
      host_val = 9'h000;
      rd_data = 9'($urandom);
      ser_out = 3'($urandom);
      rd_active = 1'h1;
      ser_oe = s;
      tick(1);
      eoe = md[0] | md[1] ? 9'h000 : md[2] | md[3] ? 9'h1f8 :
        ~(9'h080 | (single_line_output_strap ? 9'h040 : 9'h000));
      chk("oe_n", eoe, pin_oe_n);
      d = s ? {1'h0, ser_out.primary, ser_out.secondary, 6'h00} : rd_data;
      chk("out", ~eoe & d, ~eoe & pin_out);
      rd_active = 1'h0;
      ser_oe = 1'h0;
      last_result_done = 1'h1;
      tick(1);
      last_result_done = 1'h0;
      chk("crc_req", 9'(s & crc), 9'(crc_word_req_ff));
      tick(1);
      chk("crc_req_end", 9'h000, 9'(crc_word_req_ff));
      chk("oe_idle", 9'h1ff, pin_oe_n);
    end
    give_verdict();
  end
endmodule : tb
